// ---- scc_pkg.sv ----
package scc_pkg;

  // Interface-select strap codes
  localparam logic [1:0] SCC_IF_ADDR0 = 2'h0;
  localparam logic [1:0] SCC_IF_ADDR1 = 2'h1;
  localparam logic [1:0] SCC_IF_ADDR2 = 2'h2;
  localparam logic [1:0] SCC_IF_SERIAL = 2'h3;
  // Default two-wire target addresses (7 bit)
  localparam logic [6:0] SCC_ADDR_DEF0 = 7'h74;
  localparam logic [6:0] SCC_ADDR_DEF1 = 7'h75;
  localparam logic [6:0] SCC_ADDR_DEF2 = 7'h76;
  // Test-mode configuration codes
  localparam logic [2:0] SCC_CFG_PROGRAM = 3'h0;
  localparam logic [2:0] SCC_CFG_NO_BOOT = 3'h3;
  // Reference-input mode field codes
  localparam logic [1:0] SCC_REF_OFF = 2'h0;
  localparam logic [1:0] SCC_REF_XTAL = 2'h1;
  localparam logic [1:0] SCC_REF_OSC = 2'h2;
  // Fixed minimum internal load capacitance, pF
  localparam int SCC_MIN_CAP_PF = 6;
  localparam int SCC_CAP_W = 5;
  // Boot timing: ring oscillator tick divider and script length per config
  localparam int SCC_RING_DIV = 4;
  localparam int SCC_WRITE_TICKS = 2;
  localparam int SCC_SCRIPT_WORDS = 8;
  // Reset values
  localparam logic [1:0] SCC_REF_MODE_RST = 2'h0;
  localparam logic [SCC_CAP_W-1:0] SCC_CAP_RST = 5'h00;

  typedef struct packed {
    logic test;
    logic [2:0] cfg_index;
    logic [1:0] if_sel;
  } scc_straps_t;

  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
  } scc_script_wr_t;

  typedef struct packed {
    logic ref_pin_a_clk_en;
    logic xtal_drv_en;
    logic ref_dbl_on;
    logic loop1_dbl_on;
    logic loop2_dbl_on;
  } scc_ref_ctl_t;

endpackage

// ---- scc_script_rom.sv ----
`timescale 1ns/1ps
module scc_script_rom
(
  // Clock
  input wire logic mclk,
  // Read port
  input wire logic script_rd,
  input wire logic [2:0] script_sel,
  input wire logic [2:0] script_word,
  output scc_pkg::scc_script_wr_t script_data
);
  import scc_pkg::*;
  // Word held until next read; address field names script and word
  initial script_data = '0;
  always @(posedge mclk)
    if (script_rd)
      script_data <= {script_sel, script_word, 1'b1, 5'h00, script_sel};
endmodule

// ---- scc_strap_ref_cfg.sv ----
`timescale 1ns/1ps
// Function
// - Decode interface straps into address or serial
// - Config straps index one of eight scripts
// - Strap address is default; writes replace it
// - Mode 10 enables single-ended reference pin
// - Mode 01 enables crystal driver
// - Separate load-cap fields per crystal pin
// - Reference doubler enabled by its bit
// - Each loop has own input doubler bit
// - Ring oscillator clocks boot controller after reset
// - Ring disable honoured once boot complete
// - Register access needs no ring oscillator
// - Straps captured on reset pin rising edge
// - Test, config 000, if 11: programming mode
// - Test with config 011 skips boot script
module scc_strap_ref_cfg
#(
  parameter int CAP_W = scc_pkg::SCC_CAP_W,
  parameter int SCRIPT_WORDS = scc_pkg::SCC_SCRIPT_WORDS
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Device pins
  input wire logic reset_pin_low_active,
  input wire scc_pkg::scc_straps_t strap_pins,
  // Host register writes (asynchronous host path, already in mclk)
  input wire logic addr_wr,
  input wire logic [6:0] addr_wr_data,
  input wire logic ctl_wr,
  input wire logic [1:0] ref_input_mode_field,
  input wire logic ref_doubler_enable,
  input wire logic [1:0] loop_input_doubler_enable,
  input wire logic [CAP_W-1:0] pin_a_load_cap,
  input wire logic [CAP_W-1:0] pin_b_load_cap,
  input wire logic ring_osc_disable,
  // Script memory read port
  output logic script_rd,
  output logic [2:0] script_sel,
  output logic [$clog2(SCRIPT_WORDS)-1:0] script_word,
  input wire scc_pkg::scc_script_wr_t script_data,
  // Status and control outputs
  output scc_pkg::scc_straps_t strap_capture_status,
  output logic serial_mode,
  output logic nvm_program_mode,
  output logic [6:0] two_wire_target_addr_reg,
  output scc_pkg::scc_ref_ctl_t ref_ctl,
  output logic [CAP_W-1:0] pin_a_cap_total,
  output logic [CAP_W-1:0] pin_b_cap_total,
  output logic ring_osc_run,
  output logic boot_complete_flag
);
  import scc_pkg::*;

  localparam int WW = $clog2(SCRIPT_WORDS);
  localparam logic [WW-1:0] LAST_WORD = WW'(SCRIPT_WORDS - 1);
  localparam logic [CAP_W-1:0] MIN_CAP = CAP_W'(SCC_MIN_CAP_PF);
  localparam logic [2:0] RING_LAST = 3'(SCC_RING_DIV - 1);

  typedef enum logic [3:0]
  {
    SCC_IDLE = 4'h1,
    SCC_READ = 4'h2,
    SCC_WRITE = 4'h4,
    SCC_DONE = 4'h8
  } scc_state_t;

  function automatic logic [6:0] default_addr(input logic [1:0] sel);
    logic [6:0] a;
    a = SCC_ADDR_DEF0;
    case (sel)
      SCC_IF_ADDR1: a = SCC_ADDR_DEF1;
      SCC_IF_ADDR2: a = SCC_ADDR_DEF2;
      default: a = SCC_ADDR_DEF0;
    endcase
    return a;
  endfunction

  function automatic logic [CAP_W-1:0] cap_total(input logic [CAP_W-1:0] c);
    return c + MIN_CAP;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture on reset pin rising edge

  logic pin_q;
  logic pin_rise;
  logic next_pin_q;
  scc_straps_t next_straps;
  logic next_serial;
  logic next_prog;
  logic [6:0] next_addr;
  logic boot_go;
  logic next_boot_go;
  logic script_wr_valid;

  assign pin_rise = reset_pin_low_active && !pin_q;

  always_comb
  begin
    next_pin_q = reset_pin_low_active;
    next_straps = strap_capture_status;
    next_serial = serial_mode;
    next_prog = nvm_program_mode;
    next_addr = two_wire_target_addr_reg;
    next_boot_go = 1'b0;
    if (pin_rise)
    begin
      next_straps = strap_pins;
      next_serial = (strap_pins.if_sel == SCC_IF_SERIAL);
      next_addr = default_addr(strap_pins.if_sel);
      next_prog = strap_pins.test && strap_pins.cfg_index == SCC_CFG_PROGRAM
        && strap_pins.if_sel == SCC_IF_SERIAL;
      next_boot_go = 1'b1;
    end
    else if (script_wr_valid)
      next_addr = script_data.addr;
    else if (addr_wr)
      next_addr = addr_wr_data;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Boot controller on ring oscillator ticks

  scc_state_t state;
  scc_state_t next_state;
  logic [2:0] ring_cnt;
  logic [2:0] next_ring_cnt;
  logic ring_tick;
  logic [WW-1:0] next_word;
  logic [1:0] wr_cnt;
  logic [1:0] next_wr_cnt;
  logic next_rd;
  logic next_done;
  logic next_ring_run;
  logic skip_boot;

  // Ring stays off only after boot finished; earlier disables are ignored
  assign ring_tick = ring_osc_run && ring_cnt == RING_LAST;
  assign script_wr_valid = state == SCC_WRITE && ring_tick
    && wr_cnt == 2'(SCC_WRITE_TICKS - 1);
  // Captured straps are already registered in the cycle the boot launches
  assign skip_boot = strap_capture_status.test
    && (strap_capture_status.cfg_index == SCC_CFG_NO_BOOT
    || strap_capture_status.cfg_index == SCC_CFG_PROGRAM);

  always_comb
  begin
    next_state = state;
    next_ring_cnt = ring_osc_run ? ring_cnt + 3'h1 : 3'h0;
    if (ring_tick)
      next_ring_cnt = 3'h0;
    next_word = script_word;
    next_wr_cnt = wr_cnt;
    next_rd = 1'b0;
    next_done = boot_complete_flag;
    next_ring_run = ring_osc_run;
    if (boot_complete_flag && ring_osc_disable)
      next_ring_run = 1'b0;
    unique case (state)
      SCC_IDLE:
      begin
        if (boot_go)
        begin
          next_ring_run = 1'b1;
          next_word = '0;
          if (skip_boot)
          begin
            next_state = SCC_DONE;
            next_done = 1'b1;
          end
          else
            next_state = SCC_READ;
        end
      end
      SCC_READ:
      begin
        if (ring_tick)
        begin
          next_rd = 1'b1;
          next_wr_cnt = 2'h0;
          next_state = SCC_WRITE;
        end
      end
      SCC_WRITE:
      begin
        if (ring_tick)
        begin
          next_wr_cnt = wr_cnt + 2'h1;
          if (script_wr_valid)
          begin
            if (script_word == LAST_WORD)
            begin
              next_state = SCC_DONE;
              next_done = 1'b1;
            end
            else
            begin
              next_word = script_word + WW'(1);
              next_state = SCC_READ;
            end
          end
        end
      end
      SCC_DONE:
        next_state = SCC_DONE;
    endcase
    // Pin held low is a device reset; its next rise boots again
    if (!reset_pin_low_active)
    begin
      next_state = SCC_IDLE;
      next_done = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference front end, driven directly by host writes

  scc_ref_ctl_t next_ref;
  logic [CAP_W-1:0] next_cap_a;
  logic [CAP_W-1:0] next_cap_b;

  // Host path runs on mclk, independent of the ring oscillator
  always_comb
  begin
    next_ref = ref_ctl;
    next_cap_a = pin_a_cap_total;
    next_cap_b = pin_b_cap_total;
    if (ctl_wr)
    begin
      next_ref.ref_pin_a_clk_en = ref_input_mode_field == SCC_REF_OSC;
      next_ref.xtal_drv_en = ref_input_mode_field == SCC_REF_XTAL;
      next_ref.ref_dbl_on = ref_doubler_enable;
      // Chaining onto the doubled reference is left to software
      next_ref.loop1_dbl_on = loop_input_doubler_enable[0];
      next_ref.loop2_dbl_on = loop_input_doubler_enable[1];
      // Zero setting still leaves the fixed internal minimum
      next_cap_a = cap_total(pin_a_load_cap);
      next_cap_b = cap_total(pin_b_load_cap);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // Strap capture group
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      pin_q <= 1'b0;
      strap_capture_status <= '0;
      serial_mode <= 1'b0;
      nvm_program_mode <= 1'b0;
      two_wire_target_addr_reg <= SCC_ADDR_DEF0;
      boot_go <= 1'b0;
    end
    else
    begin
      pin_q <= next_pin_q;
      strap_capture_status <= next_straps;
      serial_mode <= next_serial;
      nvm_program_mode <= next_prog;
      two_wire_target_addr_reg <= next_addr;
      boot_go <= next_boot_go;
    end
  end

  // Boot controller group
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state <= SCC_IDLE;
      ring_cnt <= 3'h0;
      script_word <= '0;
      wr_cnt <= 2'h0;
      script_rd <= 1'b0;
      boot_complete_flag <= 1'b0;
      ring_osc_run <= 1'b0;
    end
    else
    begin
      state <= next_state;
      ring_cnt <= next_ring_cnt;
      script_word <= next_word;
      wr_cnt <= next_wr_cnt;
      script_rd <= next_rd;
      boot_complete_flag <= next_done;
      ring_osc_run <= next_ring_run;
    end
  end

  // Reference front end group
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      ref_ctl <= '0;
      pin_a_cap_total <= MIN_CAP;
      pin_b_cap_total <= MIN_CAP;
    end
    else
    begin
      ref_ctl <= next_ref;
      pin_a_cap_total <= next_cap_a;
      pin_b_cap_total <= next_cap_b;
    end
  end

  assign script_sel = strap_capture_status.cfg_index;

endmodule

// ---- scc_strap_ref_cfg_properties.sv ----
`timescale 1ns/1ps
module scc_strap_ref_cfg_properties
#(
  parameter int CAP_W = scc_pkg::SCC_CAP_W
)
(
  // Clock and pins
  input wire logic mclk,
  input wire logic reset,
  input wire logic reset_pin_low_active,
  input wire scc_pkg::scc_straps_t strap_pins,
  // Host writes
  input wire logic ctl_wr,
  input wire logic [1:0] ref_input_mode_field,
  input wire logic [CAP_W-1:0] pin_a_load_cap,
  input wire logic [CAP_W-1:0] pin_b_load_cap,
  input wire logic ring_osc_disable,
  // Status
  input wire scc_pkg::scc_straps_t strap_capture_status,
  input wire logic serial_mode,
  input wire logic nvm_program_mode,
  input wire logic [6:0] two_wire_target_addr_reg,
  input wire scc_pkg::scc_ref_ctl_t ref_ctl,
  input wire logic [CAP_W-1:0] pin_a_cap_total,
  input wire logic [CAP_W-1:0] pin_b_cap_total,
  input wire logic ring_osc_run,
  input wire logic boot_complete_flag
);
  import scc_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  //////////////////////////////////////////////////////////////////////////////
  a_strap_capture: assert property (
    $rose(reset_pin_low_active) |=> strap_capture_status == $past(strap_pins))
    else $error("strap status not captured");
  a_serial_decode: assert property (
    $rose(reset_pin_low_active) |=> serial_mode == ($past(strap_pins.if_sel) == SCC_IF_SERIAL))
    else $error("serial mode decode wrong");
  a_default_addr: assert property (
    $rose(reset_pin_low_active) && strap_pins.if_sel != SCC_IF_SERIAL
    |=> two_wire_target_addr_reg == SCC_ADDR_DEF0 + 7'($past(strap_pins.if_sel)))
    else $error("default address wrong");
  a_program_mode: assert property (
    $rose(reset_pin_low_active) |=> nvm_program_mode ==
    ($past(strap_pins) == {1'b1, SCC_CFG_PROGRAM, SCC_IF_SERIAL}))
    else $error("programming mode decode wrong");
  a_skip_boot: assert property (
    $rose(reset_pin_low_active) && strap_pins.test && strap_pins.cfg_index == SCC_CFG_NO_BOOT
    |-> ##2 boot_complete_flag)
    else $error("script not skipped");
  a_ref_select: assert property (
    ctl_wr |=> ref_ctl.ref_pin_a_clk_en == ($past(ref_input_mode_field) == SCC_REF_OSC)
    && ref_ctl.xtal_drv_en == ($past(ref_input_mode_field) == SCC_REF_XTAL))
    else $error("reference select wrong");
  a_cap_total: assert property (
    ctl_wr |=> pin_a_cap_total == CAP_W'($past(pin_a_load_cap) + SCC_MIN_CAP_PF)
    && pin_b_cap_total == CAP_W'($past(pin_b_load_cap) + SCC_MIN_CAP_PF))
    else $error("load cap total wrong");
  a_ring_stop: assert property (
    boot_complete_flag && ring_osc_disable |=> !ring_osc_run)
    else $error("ring oscillator not stopped");
endmodule

bind scc_strap_ref_cfg scc_strap_ref_cfg_properties #(.CAP_W(CAP_W)) scc_props_i (
  .mclk(mclk), .reset(reset), .reset_pin_low_active(reset_pin_low_active),
  .strap_pins(strap_pins), .ctl_wr(ctl_wr), .ref_input_mode_field(ref_input_mode_field),
  .pin_a_load_cap(pin_a_load_cap), .pin_b_load_cap(pin_b_load_cap),
  .ring_osc_disable(ring_osc_disable), .strap_capture_status(strap_capture_status),
  .serial_mode(serial_mode), .nvm_program_mode(nvm_program_mode),
  .two_wire_target_addr_reg(two_wire_target_addr_reg), .ref_ctl(ref_ctl),
  .pin_a_cap_total(pin_a_cap_total), .pin_b_cap_total(pin_b_cap_total),
  .ring_osc_run(ring_osc_run), .boot_complete_flag(boot_complete_flag));

// ---- scc_strap_ref_cfg_tb_top.sv ----
`timescale 1ns/1ps
module scc_strap_ref_cfg_tb_top;
  import scc_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic reset_pin_low_active = 1'b0;
  scc_straps_t strap_pins = '0;
  logic addr_wr = 1'b0;
  logic [6:0] addr_wr_data = 7'h00;
  logic ctl_wr = 1'b0;
  logic [1:0] ref_input_mode_field = 2'h0;
  logic ref_doubler_enable = 1'b0;
  logic [1:0] loop_input_doubler_enable = 2'h0;
  logic [4:0] pin_a_load_cap = 5'h00;
  logic [4:0] pin_b_load_cap = 5'h00;
  logic ring_osc_disable = 1'b0;
  logic script_rd, serial_mode, nvm_program_mode, ring_osc_run, boot_complete_flag;
  logic [2:0] script_sel, script_word;
  logic [6:0] two_wire_target_addr_reg;
  logic [4:0] pin_a_cap_total, pin_b_cap_total;
  scc_script_wr_t script_data;
  scc_straps_t strap_capture_status;
  scc_ref_ctl_t ref_ctl;
  int fails = 0;
  int comparisons = 0;

  always #20 mclk = ~mclk;

  scc_strap_ref_cfg scc_strap_ref_cfg_i (.mclk(mclk), .reset(reset),
    .reset_pin_low_active(reset_pin_low_active), .strap_pins(strap_pins),
    .addr_wr(addr_wr), .addr_wr_data(addr_wr_data), .ctl_wr(ctl_wr),
    .ref_input_mode_field(ref_input_mode_field), .ref_doubler_enable(ref_doubler_enable),
    .loop_input_doubler_enable(loop_input_doubler_enable), .pin_a_load_cap(pin_a_load_cap),
    .pin_b_load_cap(pin_b_load_cap), .ring_osc_disable(ring_osc_disable),
    .script_rd(script_rd), .script_sel(script_sel), .script_word(script_word),
    .script_data(script_data), .strap_capture_status(strap_capture_status),
    .serial_mode(serial_mode), .nvm_program_mode(nvm_program_mode),
    .two_wire_target_addr_reg(two_wire_target_addr_reg), .ref_ctl(ref_ctl),
    .pin_a_cap_total(pin_a_cap_total), .pin_b_cap_total(pin_b_cap_total),
    .ring_osc_run(ring_osc_run), .boot_complete_flag(boot_complete_flag));

  scc_script_rom scc_script_rom_i (.mclk(mclk), .script_rd(script_rd),
    .script_sel(script_sel), .script_word(script_word), .script_data(script_data));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    if (fails == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic wait_flag();
    int n;
    n = 0;
    while (boot_complete_flag !== 1'b1 && n < 400)
    begin
      @(negedge mclk);
      n++;
    end
  endtask

  // Straps set while pin low, then pin rises; checks one cycle after the capture
  task automatic strap_boot(input scc_straps_t s);
    @(posedge mclk);
    reset_pin_low_active <= 1'b0;
    strap_pins <= s;
    repeat (2) @(posedge mclk);
    reset_pin_low_active <= 1'b1;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk(16'(strap_capture_status), 16'(s));
    chk(16'(serial_mode), 16'(s.if_sel == SCC_IF_SERIAL));
    chk(16'(nvm_program_mode), 16'(s == {1'b1, SCC_CFG_PROGRAM, SCC_IF_SERIAL}));
    if (s.if_sel != SCC_IF_SERIAL)
      chk(16'(two_wire_target_addr_reg), 16'(SCC_ADDR_DEF0 + 7'(s.if_sel)));
  endtask

  // Every config index and interface code, script run to the end
  task automatic normal_boots();
    for (int i = 0; i < 8; i++)
    begin
      strap_boot({1'b0, 3'(i), 2'(i)});
      @(negedge mclk);
      chk(16'(ring_osc_run), 16'h0001);
      chk(16'(boot_complete_flag), 16'h0000);
      chk(16'(script_sel), 16'(i));
      if (i == 5)
      begin
        @(posedge mclk);
        ring_osc_disable <= 1'b1;
      end
      repeat (8) @(negedge mclk);
      chk(16'(ring_osc_run), 16'h0001);
      wait_flag();
      chk(16'(boot_complete_flag), 16'h0001);
      chk(16'(two_wire_target_addr_reg), 16'({3'(i), 3'h7, 1'b1}));
      chk(16'(script_word), 16'(SCC_SCRIPT_WORDS - 1));
    end
    @(negedge mclk);
    chk(16'(ring_osc_run), 16'h0000);
    @(posedge mclk);
    addr_wr <= 1'b1;
    addr_wr_data <= 7'h2A;
    @(posedge mclk);
    addr_wr <= 1'b0;
    ring_osc_disable <= 1'b0;
    @(negedge mclk);
    chk(16'(two_wire_target_addr_reg), 16'h002A);
    repeat (20) @(negedge mclk);
    chk(16'(boot_complete_flag), 16'h0001);
  endtask

  task automatic test_modes();
    strap_boot({1'b1, SCC_CFG_NO_BOOT, SCC_IF_ADDR0});
    @(negedge mclk);
    chk(16'(boot_complete_flag), 16'h0001);
    repeat (40) @(negedge mclk);
    chk(16'(two_wire_target_addr_reg), 16'(SCC_ADDR_DEF0));
    strap_boot({1'b1, SCC_CFG_PROGRAM, SCC_IF_SERIAL});
    @(negedge mclk);
    chk(16'(boot_complete_flag), 16'h0001);
  endtask

  // Doublers never chained; first entry zeroes both caps
  task automatic ref_setup();
    for (int k = 0; k < 4; k++)
    begin
      @(posedge mclk);
      ctl_wr <= 1'b1;
      ref_input_mode_field <= 2'(k);
      ref_doubler_enable <= (k == 1);
      loop_input_doubler_enable <= 2'(k >> 1) << (k & 1);
      pin_a_load_cap <= 5'(3 * k);
      pin_b_load_cap <= (k == 0) ? 5'h00 : 5'(20 + k);
      @(posedge mclk);
      ctl_wr <= 1'b0;
      @(negedge mclk);
      chk(16'(ref_ctl), 16'({k == 2, k == 1, k == 1, k == 2, k == 3}));
      chk(16'(pin_a_cap_total), 16'(3 * k + 6));
      chk(16'(pin_b_cap_total), 16'((k == 0) ? 6 : 26 + k));
    end
  endtask

  initial
  begin
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    ref_setup();
    normal_boots();
    test_modes();
    give_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    fails++;
    give_verdict();
  end
endmodule
